// >>> src/pdc_pkg.sv
// package for the device control register block: offsets, fields, resets
// assumes nothing of its surroundings
`default_nettype none
package pdc_pkg;
   // -----------------------------------------
   // register map
   // -----------------------------------------
   localparam logic [7:0] PDC_DEVICE_CONTROL_OFFSET = 8'h48;
   localparam logic [7:0] PDC_SEQ_TAG_CTRL_OFFSET = 8'h4C;
   localparam logic [15:0] PDC_DEVICE_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] PDC_DEVICE_CONTROL_WMASK = 16'h01EF;
   // -----------------------------------------
   // field positions
   // -----------------------------------------
   localparam int PDC_CORR_ERR_BIT = 0;
   localparam int PDC_NONFATAL_ERR_BIT = 1;
   localparam int PDC_FATAL_ERR_BIT = 2;
   localparam int PDC_UNSUP_REQ_BIT = 3;
   localparam int PDC_RELAXED_ORDER_BIT = 4;
   localparam int PDC_MPS_LSB = 5;
   localparam int PDC_MPS_MSB = 7;
   localparam int PDC_EXT_TAG_BIT = 8;
   localparam int PDC_SEQ_TAG_BIT = 0;
   // -----------------------------------------
   // payload codes and tag limits
   // -----------------------------------------
   localparam logic [2:0] PDC_MPS_128 = 3'h0;
   localparam logic [2:0] PDC_MPS_MAX_CODE = 3'h4;
   localparam logic [7:0] PDC_TAG_LIMIT_SHORT = 8'h1F;
   localparam logic [7:0] PDC_TAG_LIMIT_LONG = 8'hFF;
   localparam logic [11:0] PDC_PAYLOAD_BYTES_BASE = 12'h080;
   localparam logic [2:0] PDC_MAX_READ_REQ_SIZE_CODE = 3'h0;
endpackage
`default_nettype wire

// >>> src/pdc_payload_decode.sv
// payload size decoder: code to byte limit
// assumes a registered code on its input
`default_nettype none
module pdc_payload_decode
   import pdc_pkg::*;
(
   // code in
   input wire logic [2:0] code_in,
   // limits out
   output logic [2:0] eff_code_out,
   output logic [11:0] bytes_out
);
   // -----------------------------------------
   // decode
   // -----------------------------------------
   always_comb begin
      if (code_in > PDC_MPS_MAX_CODE) begin
         eff_code_out = PDC_MPS_128;
      end else begin
         eff_code_out = code_in;
      end
      bytes_out = PDC_PAYLOAD_BYTES_BASE << eff_code_out;
   end
endmodule
`default_nettype wire

// >>> src/pdc_tag_gen.sv
// sequential tag generator used in debug mode
// assumes a one-cycle next pulse from the same clock
`default_nettype none
module pdc_tag_gen
   import pdc_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // control
   input wire logic enable_in,
   input wire logic ext_tag_in,
   input wire logic next_in,
   // tag
   output logic [7:0] tag_out
);
   logic [7:0] tag_q;
   logic [7:0] limit;
   assign limit = ext_tag_in ? PDC_TAG_LIMIT_LONG : PDC_TAG_LIMIT_SHORT;
   // -----------------------------------------
   // counter
   // -----------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tag_q <= 8'h00;
      end else if (ce_in) begin
         if (!enable_in) begin
            tag_q <= 8'h00;
         end else if (next_in) begin
            // wraps at the limit, also pulls back when range shrinks
            tag_q <= (tag_q >= limit) ? 8'h00 : tag_q + 8'h01;
         end
      end
   end
   assign tag_out = tag_q;
endmodule
`default_nettype wire

// >>> src/pdc_device_control.sv
// device control register of a switch port, with its derived controls
// assumes a same-clock register master with one-cycle strobes
//
// Added by the designer: the address-and-strobe port.
`default_nettype none
module pdc_device_control
   import pdc_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   // error events from the port
   input wire logic corr_err_in,
   input wire logic nonfatal_err_in,
   input wire logic fatal_err_in,
   input wire logic unsup_req_in,
   // gated error reports
   output logic corr_err_report_out,
   output logic nonfatal_err_report_out,
   output logic fatal_err_report_out,
   output logic unsup_req_report_out,
   // originated request attributes
   output logic relaxed_order_out,
   output logic no_snoop_out,
   output logic [2:0] max_read_req_size_out,
   // forwarded attributes pass through
   input wire logic fwd_no_snoop_in,
   input wire logic [9:0] fwd_length_in,
   output logic fwd_no_snoop_out,
   output logic [9:0] fwd_length_out,
   // payload limit
   output logic [2:0] max_payload_code_out,
   output logic [11:0] max_payload_bytes_out,
   // debug tags
   input wire logic tag_next_in,
   output logic [7:0] tag_out
);
   // -----------------------------------------
   // reset synchroniser
   // -----------------------------------------
   logic rst_meta_q;
   logic rst_n_q;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // -----------------------------------------
   // register storage
   // -----------------------------------------
   logic [15:0] device_control_q;
   logic sequential_tag_debug_q;
   logic [15:0] rdata_q;
   logic [11:0] payload_bytes;
   logic [2:0] payload_code;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         device_control_q <= PDC_DEVICE_CONTROL_RESET;
      end else if (ce_in && wr_in && hit(addr_in, PDC_DEVICE_CONTROL_OFFSET)) begin
         // only rw fields take the write; fixed bits keep zero
         device_control_q <= wdata_in & PDC_DEVICE_CONTROL_WMASK;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sequential_tag_debug_q <= 1'b0;
      end else if (ce_in && wr_in && hit(addr_in, PDC_SEQ_TAG_CTRL_OFFSET)) begin
         sequential_tag_debug_q <= wdata_in[PDC_SEQ_TAG_BIT];
      end
   end

   // -----------------------------------------
   // read port
   // -----------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= 16'h0000;
      end else if (ce_in) begin
         if (rd_in && hit(addr_in, PDC_DEVICE_CONTROL_OFFSET)) begin
            rdata_q <= device_control_q & PDC_DEVICE_CONTROL_WMASK;
         end else if (rd_in && hit(addr_in, PDC_SEQ_TAG_CTRL_OFFSET)) begin
            rdata_q <= {15'h0000, sequential_tag_debug_q};
         end else begin
            // unmapped reads and idle cycles give zero
            rdata_q <= 16'h0000;
         end
      end
   end
   assign rdata_out = rdata_q;

   // -----------------------------------------
   // error report gating
   // -----------------------------------------
   logic [3:0] report_q;
   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         report_q <= 4'h0;
      end else if (ce_in) begin
         report_q[0] <= corr_err_in & device_control_q[PDC_CORR_ERR_BIT];
         report_q[1] <= nonfatal_err_in & device_control_q[PDC_NONFATAL_ERR_BIT];
         report_q[2] <= fatal_err_in & device_control_q[PDC_FATAL_ERR_BIT];
         report_q[3] <= unsup_req_in & device_control_q[PDC_UNSUP_REQ_BIT];
      end
   end
   assign corr_err_report_out = report_q[0];
   assign nonfatal_err_report_out = report_q[1];
   assign fatal_err_report_out = report_q[2];
   assign unsup_req_report_out = report_q[3];

   // -----------------------------------------
   // fixed attributes of originated requests
   // -----------------------------------------
   assign relaxed_order_out = 1'b0;
   assign no_snoop_out = 1'b0;
   // originated reads stay at the smallest size whatever software wants
   assign max_read_req_size_out = PDC_MAX_READ_REQ_SIZE_CODE;

   // -----------------------------------------
   // forwarded attributes, registered unchanged
   // -----------------------------------------
   logic fwd_no_snoop_q;
   logic [9:0] fwd_length_q;
   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fwd_no_snoop_q <= 1'b0;
         fwd_length_q <= 10'h000;
      end else if (ce_in) begin
         fwd_no_snoop_q <= fwd_no_snoop_in;
         fwd_length_q <= fwd_length_in;
      end
   end
   assign fwd_no_snoop_out = fwd_no_snoop_q;
   assign fwd_length_out = fwd_length_q;

   // -----------------------------------------
   // payload size
   // -----------------------------------------
   pdc_payload_decode u_payload (
      .code_in(device_control_q[PDC_MPS_MSB:PDC_MPS_LSB]),
      .eff_code_out(payload_code),
      .bytes_out(payload_bytes)
   );
   logic [2:0] payload_code_q;
   logic [11:0] payload_bytes_q;
   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         payload_code_q <= PDC_MPS_128;
         payload_bytes_q <= PDC_PAYLOAD_BYTES_BASE;
      end else if (ce_in) begin
         payload_code_q <= payload_code;
         payload_bytes_q <= payload_bytes;
      end
   end
   assign max_payload_code_out = payload_code_q;
   assign max_payload_bytes_out = payload_bytes_q;

   // -----------------------------------------
   // debug tag generation
   // -----------------------------------------
   // extended tag bit only matters here; normal traffic never needs tags
   pdc_tag_gen u_tag (
      .clk_in(clk_in),
      .rst_n_in(rst_n_q),
      .ce_in(ce_in),
      .enable_in(sequential_tag_debug_q),
      .ext_tag_in(device_control_q[PDC_EXT_TAG_BIT]),
      .next_in(tag_next_in),
      .tag_out(tag_out)
   );
endmodule
`default_nettype wire

// >>> test/pdc_device_control_chk.sv
// checker for the device control register block
// assumes a bind onto the top module, seeing only its ports
`default_nettype none
module pdc_device_control_chk
   import pdc_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // watched ports
   input wire logic rd_in,
   input wire logic [15:0] rdata_out,
   input wire logic corr_err_in,
   input wire logic corr_err_report_out,
   input wire logic fatal_err_in,
   input wire logic fatal_err_report_out,
   input wire logic relaxed_order_out,
   input wire logic no_snoop_out,
   input wire logic [2:0] max_read_req_size_out,
   input wire logic fwd_no_snoop_in,
   input wire logic [9:0] fwd_length_in,
   input wire logic fwd_no_snoop_out,
   input wire logic [9:0] fwd_length_out,
   input wire logic [2:0] max_payload_code_out,
   input wire logic [11:0] max_payload_bytes_out,
   input wire logic tag_next_in,
   input wire logic [7:0] tag_out
);
   // -----------------------------------------
   // assertions
   // -----------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   a_read_data_gap: assert property (rdata_out != 16'h0000 |-> $past(rd_in))
      else $error("read data without a read");
   a_fixed_bits_zero: assert property ((rdata_out & 16'hFE10) == 16'h0000)
      else $error("fixed bit read as one");
   a_corr_report: assert property (corr_err_report_out |-> $past(corr_err_in))
      else $error("correctable report without event");
   a_fatal_report: assert property (fatal_err_report_out |-> $past(fatal_err_in))
      else $error("fatal report without event");
   a_attr_zero: assert property (!relaxed_order_out && !no_snoop_out)
      else $error("originated attribute set");
   a_max_read_req_size_zero: assert property (max_read_req_size_out == 3'h0)
      else $error("read request size not zero");
   a_fwd_pass: assert property (fwd_no_snoop_out == $past(fwd_no_snoop_in)
      && fwd_length_out == $past(fwd_length_in)) else $error("forwarded field altered");
   a_payload_map: assert property (max_payload_code_out <= 3'h4
      && max_payload_bytes_out == (12'h080 << max_payload_code_out))
      else $error("payload bytes do not match code");
   a_tag_moves: assert property ($changed(tag_out) |-> $past(tag_next_in) || tag_out == 8'h00)
      else $error("tag moved without next");
endmodule
`default_nettype wire

// >>> test/pdc_device_control_tb.sv
// testbench for the device control register block
// assumes the package and design sources are compiled first
`default_nettype none
module pdc_device_control_tb;
   import pdc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic tag_next_in = 1'b0;
   logic ce = 1'b1;
   logic fwd_ns = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [15:0] wdata_in = 16'h0000;
   logic [3:0] ev = 4'h0;
   logic [9:0] fwd_len = 10'h000;
   logic [15:0] rdata_out;
   logic [3:0] rep;
   logic [2:0] code;
   logic [11:0] bytes;
   logic [7:0] tag;
   int errors = 0;
   int checks = 0;
   always #2.5 clk_in = ~clk_in;
   pdc_device_control u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .corr_err_in(ev[0]), .nonfatal_err_in(ev[1]),
      .fatal_err_in(ev[2]), .unsup_req_in(ev[3]), .corr_err_report_out(rep[0]),
      .nonfatal_err_report_out(rep[1]), .fatal_err_report_out(rep[2]),
      .unsup_req_report_out(rep[3]), .relaxed_order_out(), .no_snoop_out(),
      .max_read_req_size_out(), .fwd_no_snoop_in(fwd_ns), .fwd_length_in(fwd_len),
      .fwd_no_snoop_out(), .fwd_length_out(), .max_payload_code_out(code),
      .max_payload_bytes_out(bytes), .tag_next_in(tag_next_in), .tag_out(tag));
   // -----------------------------------------
   // shared tasks
   // -----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      chk(rdata_out, exp);
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk_in);
         tag_next_in <= 1'b1;
         @(posedge clk_in);
         tag_next_in <= 1'b0;
      end
      @(negedge clk_in);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // -----------------------------------------
   // scenarios
   // -----------------------------------------
   task automatic t_reset();
      rd(8'h48, 16'h0000);
      chk({4'h0, bytes}, 16'h0080);
      rd(8'h4C, 16'h0000);
      rd(8'h00, 16'h0000);
      $display("reset values done");
   endtask
   task automatic t_fixed();
      wr(8'h48, 16'hFFFF);
      rd(8'h48, 16'h01EF);
      chk({13'h0, code}, 16'h0000);
      $display("fixed bits done");
   endtask
   task automatic t_mps();
      logic [2:0] e;
      for (int c = 0; c < 8; c++) begin
         e = (c > 4) ? 3'h0 : 3'(c);
         wr(8'h48, 16'(c) << 5);
         rd(8'h48, 16'(c) << 5);
         chk({13'h0, code}, {13'h0, e});
         chk({4'h0, bytes}, {4'h0, 12'h080 << e});
      end
      $display("payload codes done");
   endtask
   // complementary enable sets, so each report is seen both gated and passed
   task automatic t_reports(input logic [3:0] en);
      wr(8'h48, {12'h000, en});
      @(posedge clk_in);
      ev <= 4'hF;
      fwd_ns <= ~fwd_ns;
      fwd_len <= {en, 6'h2A};
      @(posedge clk_in);
      ev <= 4'h0;
      @(negedge clk_in);
      chk({12'h000, rep}, {12'h000, en});
      $display("reports %h done", en);
   endtask
   // a write taken while the enable is low must leave the register alone
   task automatic t_freeze();
      wr(8'h48, 16'h0003);
      @(posedge clk_in);
      ce <= 1'b0;
      wr(8'h48, 16'h00E0);
      @(posedge clk_in);
      ce <= 1'b1;
      rd(8'h48, 16'h0003);
      $display("freeze done");
   endtask
   task automatic t_tags();
      wr(8'h4C, 16'h0001);
      wr(8'h48, 16'h0000);
      pulses(31);
      chk({8'h00, tag}, 16'h001F);
      pulses(1);
      chk({8'h00, tag}, 16'h0000);
      wr(8'h48, 16'h0100);
      pulses(32);
      chk({8'h00, tag}, 16'h0020);
      wr(8'h4C, 16'h0000);
      $display("tags done");
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      t_reset();
      t_fixed();
      t_mps();
      t_reports(4'h5);
      t_reports(4'hA);
      t_freeze();
      t_tags();
      tally_and_finish();
   end
   initial begin
      #20us;
      errors++;
      tally_and_finish();
   end
endmodule
bind pdc_device_control pdc_device_control_chk u_chk (.clk_in(clk_in),
   .reset_n_in(reset_n_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .corr_err_in(corr_err_in), .corr_err_report_out(corr_err_report_out),
   .fatal_err_in(fatal_err_in), .fatal_err_report_out(fatal_err_report_out),
   .relaxed_order_out(relaxed_order_out), .no_snoop_out(no_snoop_out),
   .max_read_req_size_out(max_read_req_size_out), .fwd_no_snoop_in(fwd_no_snoop_in),
   .fwd_length_in(fwd_length_in), .fwd_no_snoop_out(fwd_no_snoop_out),
   .fwd_length_out(fwd_length_out), .max_payload_code_out(max_payload_code_out),
   .max_payload_bytes_out(max_payload_bytes_out), .tag_next_in(tag_next_in),
   .tag_out(tag_out));
`default_nettype wire
